// ==== rtl/pmfc_pkg.sv ====
// package for the three-phase pwm function control block
// assumes a classic wishbone slave with 32-bit data and byte addresses
package pmfc_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] FCR_IDX = 10'h13a;
    localparam logic [9:0] OME1_IDX = 10'h13b;
    localparam logic [9:0] OME2_IDX = 10'h13c;
    localparam logic [9:0] RUN_IDX = 10'h137;
    localparam logic [11:0] FCR_ADDR = {FCR_IDX, 2'b00};
    localparam logic [11:0] OME1_ADDR = {OME1_IDX, 2'b00};
    localparam logic [11:0] OME2_ADDR = {OME2_IDX, 2'b00};
    localparam logic [11:0] RUN_ADDR = {RUN_IDX, 2'b00};
    localparam logic [7:0] FCR_RESET = 8'h80;
    localparam logic [7:0] OME1_RESET = 8'hff;
    localparam logic [7:0] OME2_RESET = 8'h7f;
    localparam logic [7:0] OME2_UNUSED = 8'h7f;
    localparam logic [7:0] RUN_RESET = 8'hfc;
    localparam logic [7:0] RUN_UNUSED = 8'hf0;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [1:0] COMB_PLAIN = 2'b00;
    localparam int CUTOFF_BIT = 7;
    localparam int MODE_BIT = 7;

    typedef struct packed {
        logic three_phase_mode_select;
        logic external_clock_select;
        logic conversion_trigger_edge;
        logic conversion_trigger_enable;
        logic counter_phase_level_select;
        logic normal_phase_level_select;
        logic [1:0] combination_select;
    } pmfc_fcr_s;

    // settings as seen by the counting logic
    typedef struct packed {
        logic three_phase_active;
        logic normal_phase_level_select;
        logic counter_phase_level_select;
        logic conversion_trigger_enable;
        logic conversion_trigger_edge;
        logic external_clock_select;
        logic [1:0] combination_select;
    } pmfc_cfg_s;
endpackage : pmfc_pkg

// ==== rtl/pmfc_sync.sv ====
// two-flop synchroniser for a pin level
// assumes the pin is asynchronous to clk_i
module pmfc_sync (
    input wire logic clk_i,  // system clock
    input wire logic rst_i,  // sync reset, high
    input wire logic d_i,    // async level
    output logic q_o         // synchronised level
);
    logic meta_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= 1'b1;
            q_o <= 1'b1;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : pmfc_sync

// ==== rtl/pmfc_top.sv ====
// function control and forced cutoff registers of the pwm timer
// assumes a classic wishbone master on clk_i and an async cutoff pin
//
// Decided for this implementation: the Wishbone register port.
module pmfc_top
    import pmfc_pkg::*;
(
    input wire logic clk_i,                 // 50 mhz clock
    input wire logic rst_i,                 // sync reset, high
    input wire logic wb_cyc_i,              // bus cycle
    input wire logic wb_stb_i,              // strobe
    input wire logic wb_we_i,               // write enable
    input wire logic [11:0] wb_adr_i,       // byte address
    input wire logic [3:0] wb_sel_i,        // byte selects
    input wire logic [31:0] wb_dat_i,       // write data
    output logic [31:0] wb_dat_o,           // read data
    output logic wb_ack_o,                  // acknowledge
    output logic wb_err_o,                  // unmapped address
    input wire logic cutoff_input_pin_i,    // async cutoff pin, low acts
    output pmfc_pkg::pmfc_cfg_s cfg_o,      // effective settings
    output logic [7:0] out_disable_o,       // output master enable one
    output logic [1:0] run_o                // channel run flags
);
    import pmfc_pkg::*;

    pmfc_fcr_s fcr_q;
    logic [7:0] ome1_q;
    logic ome2_pto_q;
    logic [3:0] run_q;
    logic ack_q;
    logic err_q;
    logic [31:0] rdat_q;
    pmfc_cfg_s cfg_q;
    logic pin_s;

    pmfc_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(cutoff_input_pin_i),
        .q_o(pin_s)
    );

    wire req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    wire lane0 = wb_sel_i[0];
    wire hit_fcr = wb_adr_i == FCR_ADDR;
    wire hit_ome1 = wb_adr_i == OME1_ADDR;
    wire hit_ome2 = wb_adr_i == OME2_ADDR;
    wire hit_run = wb_adr_i == RUN_ADDR;
    wire hit_any = hit_fcr || hit_ome1 || hit_ome2 || hit_run;
    wire wr = req && wb_we_i && lane0;
    wire wr_fcr = wr && hit_fcr;
    wire wr_ome1 = wr && hit_ome1;
    wire wr_ome2 = wr && hit_ome2;
    wire wr_run = wr && hit_run;
    wire [7:0] wbyte = wb_dat_i[7:0];
    // only the synchronised level is read: the raw pin may be metastable
    wire forced = ome2_pto_q && !pin_s;
    wire mode_on = fcr_q.combination_select == COMB_PLAIN
        && !fcr_q.three_phase_mode_select;

    wire [7:0] rd_byte =
        hit_fcr ? fcr_q :
        hit_ome1 ? ome1_q :
        hit_ome2 ? ({ome2_pto_q, 7'h00} | OME2_UNUSED) :
        hit_run ? ({4'h0, run_q} | RUN_UNUSED) : 8'h00;

    // cfg: in three-phase mode the level and trigger bits read as zero
    // to the counters while staying readable to software
    pmfc_cfg_s cfg_d;
    assign cfg_d.three_phase_active = mode_on;
    assign cfg_d.normal_phase_level_select =
        fcr_q.normal_phase_level_select && !mode_on;
    assign cfg_d.counter_phase_level_select =
        fcr_q.counter_phase_level_select && !mode_on;
    assign cfg_d.conversion_trigger_enable =
        fcr_q.conversion_trigger_enable && !mode_on;
    assign cfg_d.conversion_trigger_edge =
        fcr_q.conversion_trigger_edge && !mode_on;
    assign cfg_d.external_clock_select = fcr_q.external_clock_select;
    assign cfg_d.combination_select = fcr_q.combination_select;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h0;
        end
        else
        begin
            ack_q <= req && hit_any;
            err_q <= req && !hit_any;
            rdat_q <= (req && hit_any) ? {24'h0, rd_byte} : 32'h0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fcr_q <= FCR_RESET;
            ome2_pto_q <= 1'b0;
            run_q <= RUN_RESET[3:0];
        end
        else
        begin
            if (wr_fcr)
                fcr_q <= wbyte;
            if (wr_ome2)
                ome2_pto_q <= wbyte[CUTOFF_BIT];
            if (wr_run)
                run_q <= wbyte[3:0];
        end
    end

    // the forced value wins over a software write in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ome1_q <= OME1_RESET;
        else if (forced)
            ome1_q <= ALL_ONES;
        else if (wr_ome1)
            ome1_q <= wbyte;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_q <= '0;
        else
            cfg_q <= cfg_d;
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;
    assign out_disable_o = ome1_q;
    assign run_o = run_q[1:0];
    assign cfg_o = cfg_q;

    sequence cut_cond_s;
        ome2_pto_q && !pin_s;
    endsequence

    cutoff_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cut_cond_s |=> out_disable_o == ALL_ONES)
        else $error("cutoff did not force all disables");
    cutoff_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ome2_pto_q && wr_ome1 |=> out_disable_o == $past(wbyte))
        else $error("disarmed cutoff blocked a write");
    pin_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ome2_pto_q && !cutoff_input_pin_i ##1 ome2_pto_q
        && !cutoff_input_pin_i ##1 ome2_pto_q
        |=> out_disable_o == ALL_ONES)
        else $error("pin low not acted on in time");
    ignore_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_on |=> !cfg_o.normal_phase_level_select
        && !cfg_o.counter_phase_level_select
        && !cfg_o.conversion_trigger_edge
        && !cfg_o.conversion_trigger_enable)
        else $error("ignored bits reached counters");
    mode_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fcr_q.combination_select != COMB_PLAIN
        |=> !cfg_o.three_phase_active)
        else $error("mode active with wrong combination");
    mode_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fcr_q.combination_select == COMB_PLAIN
        && !fcr_q[MODE_BIT] |=> cfg_o.three_phase_active)
        else $error("mode bit zero did not select mode");
    unused_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && hit_ome2 |=> wb_ack_o
        && wb_dat_o[6:0] == 7'h7f)
        else $error("unused bits did not read one");
    run_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_run |=> run_o == $past(wb_dat_i[1:0]))
        else $error("run flag write lost");

    // bus answer timing and refusals
    sequence take_map_s;
        req && hit_any;
    endsequence

    sequence take_unmap_s;
        req && !hit_any;
    endsequence

    sequence refused_run_s;
        req && wb_we_i && !lane0 && hit_run;
    endsequence

    ack_answer_a: assert property (@(posedge clk_i)
        disable iff (rst_i) take_map_s |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acknowledged");
    err_answer_a: assert property (@(posedge clk_i)
        disable iff (rst_i) take_unmap_s |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not refused");
    ack_pulse_a: assert property (@(posedge clk_i)
        disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held too long");
    lane_refuse_a: assert property (@(posedge clk_i)
        disable iff (rst_i) refused_run_s |=> $stable(run_o))
        else $error("write without low lane changed run flags");
    fcr_store_a: assert property (@(posedge clk_i)
        disable iff (rst_i) wr_fcr |=> fcr_q == $past(wbyte))
        else $error("function control write lost");
    cfg_pass_a: assert property (@(posedge clk_i)
        disable iff (rst_i) !mode_on |=> cfg_o.normal_phase_level_select
        == $past(fcr_q.normal_phase_level_select))
        else $error("level bit lost outside three-phase");
    // disarmed cutoff: the pin level must not move the enables
    disarm_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i) !ome2_pto_q && !wr_ome1
        |=> $stable(out_disable_o))
        else $error("disarmed cutoff pin changed the enables");
endmodule : pmfc_top

// ==== verification/pmfc_top_tb.sv ====
// self-checking bench for the function control and cutoff registers
// assumes the one-cycle registered bus answer and 3-edge cutoff path
module pmfc_top_tb
    import pmfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h1;
    logic [3:0] lane = 4'h1;
    logic pin = 1'b1;
    logic [31:0] rdat;
    logic ack;
    logic err;
    pmfc_cfg_s cfg;
    logic [7:0] dis;
    logic [1:0] run;
    logic [7:0] r;
    logic e;
    int n_mismatch = 0;
    int checked = 0;

    always #10 clk_i = ~clk_i;

    pmfc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .cutoff_input_pin_i(pin), .cfg_o(cfg), .out_disable_o(dis),
        .run_o(run));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // the slave answer decides the length; only the count bounds it
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= lane;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (!(ack || err) && n < 20);
        if (n >= 20)
            chk(8'h00, 8'h01);
        r = rdat[7:0];
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    // registered outputs are looked at half a cycle after their edge
    task automatic settle;
        @(negedge clk_i);
    endtask : settle

    task automatic t_reset;
        bus(1'b0, FCR_ADDR, 8'h0);
        chk(r, 8'h80);
        chk(cfg, 8'h00);
        bus(1'b0, OME1_ADDR, 8'h0);
        chk(r, 8'hff);
        bus(1'b0, OME2_ADDR, 8'h0);
        chk(r, 8'h7f);
        bus(1'b0, RUN_ADDR, 8'h0);
        chk(r, 8'hfc);
    endtask : t_reset

    task automatic t_fcr;
        bus(1'b1, FCR_ADDR, 8'h3c);
        bus(1'b0, FCR_ADDR, 8'h0);
        chk(r, 8'h3c);
        chk(cfg, 8'h80);
        bus(1'b1, FCR_ADDR, 8'h01);
        settle();
        chk(cfg, 8'h01);
        bus(1'b1, FCR_ADDR, 8'h7d);
        settle();
        chk(cfg, 8'h7d);
        bus(1'b1, FCR_ADDR, 8'h00);
        settle();
        chk(cfg, 8'h80);
    endtask : t_fcr

    task automatic t_cutoff;
        bus(1'b1, OME1_ADDR, 8'h00);
        chk(dis, 8'h00);
        pin <= 1'b0;
        repeat (4) @(posedge clk_i);
        settle();
        chk(dis, 8'h00);
        @(posedge clk_i);
        pin <= 1'b1;
        bus(1'b1, OME2_ADDR, 8'h80);
        bus(1'b0, OME2_ADDR, 8'h0);
        chk(r, 8'hff);
        @(posedge clk_i);
        pin <= 1'b0;
        repeat (2) @(posedge clk_i);
        settle();
        chk(dis, 8'h00);
        @(posedge clk_i);
        settle();
        chk(dis, 8'hff);
        // forcing must win over a software clear
        bus(1'b1, OME1_ADDR, 8'h00);
        chk(dis, 8'hff);
        pin <= 1'b1;
    endtask : t_cutoff

    task automatic t_run;
        bus(1'b1, RUN_ADDR, 8'h03);
        chk({6'h0, run}, 8'h03);
        bus(1'b0, RUN_ADDR, 8'h0);
        chk(r, 8'hf3);
        bus(1'b1, RUN_ADDR, 8'h00);
        chk({6'h0, run}, 8'h00);
        // a write without the low byte lane is acknowledged but ignored
        lane = 4'h2;
        bus(1'b1, RUN_ADDR, 8'h03);
        lane = 4'h1;
        chk({6'h0, run}, 8'h00);
        bus(1'b0, 12'h000, 8'h0);
        chk({7'h0, e}, 8'h01);
    endtask : t_run

    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_fcr();
        t_cutoff();
        t_run();
        final_report();
    end

    initial
    begin
        repeat (3000) @(posedge clk_i);
        n_mismatch++;
        final_report();
    end
endmodule : pmfc_top_tb
